//--- hw/pm_state_pkg.sv
// shared types and constants of the link and device power state block
package pm_state_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS    = 10;
   localparam int L0S_IDLE_TIME_NS = 1000;
   localparam int L1_IDLE_TIME_NS  = 10000;
   localparam int L0S_IDLE_CYCLES  = (L0S_IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int L1_IDLE_CYCLES   = (L1_IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************************************
   // field values and reset values
   // ****************************************************************
   localparam logic [1:0] PWR_STATE_D3     = 2'h3;
   localparam logic [1:0] PWR_STATE_RESET  = 2'h0;
   localparam logic       SYNC_RESET_VALUE = 1'h0;
   localparam logic       PIN_DRIVE_LEVEL  = 1'h0;

   // ****************************************************************
   // state types
   // ****************************************************************
   typedef enum logic [2:0] {
      LINK_LDN,
      LINK_L0,
      LINK_L0S,
      LINK_L1_ASPM,
      LINK_L1,
      LINK_L23_READY,
      LINK_L2
   } link_state_t;

   typedef enum logic [1:0] {
      DEV_D0,
      DEV_D3HOT,
      DEV_D3COLD
   } dev_state_t;

   // configuration bits from the config register space
   typedef struct packed {
      logic       l0s_en;
      logic       l1_en;
      logic       partner_l1_en;
      logic       clk_mgmt_en;
      logic [1:0] power_state;
   } pm_cfg_t;

   // events from the link layer, same clock
   typedef struct packed {
      logic link_up;
      logic link_down;
      logic tx_idle;
      logic link_idle;
      logic pme_turn_off_rx;
      logic pme_to_ack_sent;
   } link_event_t;

   // status toward the rest of the controller
   typedef struct packed {
      link_state_t link_state;
      dev_state_t  dev_state;
      logic        txn_allowed;
      logic        cfg_msg_accept;
      logic        tx_l0s_req;
      logic        l1_entry_req;
      logic        pme_to_ack_req;
   } pm_status_t;

endpackage

//--- hw/pin_sync.sv
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
`default_nettype none
module pin_sync
   import pm_state_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] pin_sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   if (WIDTH < 1) begin : g_check
      $error("pin_sync: WIDTH must be at least 1");
   end

   always_comb begin
      next_state      = state;
      next_state.meta = pin_in;
      next_state.sync = state.meta;
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state <= '{meta: {WIDTH{SYNC_RESET_VALUE}}, sync: {WIDTH{SYNC_RESET_VALUE}}};
      end else begin
         state <= next_state;
      end
   end

   assign pin_sync_out = state.sync;

endmodule // pin_sync
`default_nettype wire

//--- hw/idle_timer.sv
// counts consecutive idle cycles and flags when the limit is reached
`timescale 1ns/1ns
`default_nettype none
module idle_timer
   import pm_state_pkg::*;
#(
   parameter int LIMIT = 100,
   parameter int CW    = 16
) (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic enable,
   input  wire logic idle,
   output var  logic expired
);

   typedef struct packed {
      logic [CW-1:0] count;
      logic          expired;
   } timer_state_t;

   timer_state_t state;
   timer_state_t next_state;

   if (LIMIT < 1 || LIMIT >= (2 ** CW)) begin : g_check
      $error("idle_timer: LIMIT does not fit CW");
   end

   always_comb begin
      next_state = state;
      if (!enable || !idle) begin
         next_state.count   = '0;
         next_state.expired = 1'b0;
      end else if (state.count == CW'(LIMIT - 1)) begin
         next_state.expired = 1'b1;
      end else begin
         next_state.count = state.count + CW'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state <= '{count: '0, expired: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign expired = state.expired;

endmodule // idle_timer
`default_nettype wire

//--- hw/pm_state_ctrl.sv
// link and device power state control with clock request pin
`timescale 1ns/1ns
`default_nettype none
module pm_state_ctrl
   import pm_state_pkg::*;
#(
   parameter int L0S_IDLE = L0S_IDLE_CYCLES,
   parameter int L1_IDLE  = L1_IDLE_CYCLES,
   parameter int IDLE_CW  = 16
) (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        perst_pin_n,
   input  wire pm_cfg_t     cfg,
   input  wire link_event_t link_evt,
   input  wire logic        clk_request_pin_in,
   output var  logic        clk_request_pin_out,
   output var  logic        clk_request_pin_oe,
   output var  logic        clk_request_seen_n,
   output var  pm_status_t  status
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (L0S_IDLE < 1 || L1_IDLE < 1) begin : g_check
      $error("pm_state_ctrl: idle limits must be at least 1");
   end

   if (IDLE_CW < 2 || IDLE_CW > 30) begin : g_check_cw
      $error("pm_state_ctrl: IDLE_CW must lie between 2 and 30");
   end

   if (L0S_IDLE >= (2 ** IDLE_CW) || L1_IDLE >= (2 ** IDLE_CW)) begin : g_check_fit
      $error("pm_state_ctrl: idle limits do not fit IDLE_CW");
   end

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      pm_cfg_t     cfg;
      link_state_t link_state;
      dev_state_t  dev_state;
      logic        txn_allowed;
      logic        cfg_msg_accept;
      logic        tx_l0s_req;
      logic        l1_entry_req;
      logic        pme_to_ack_req;
      logic        turn_off_seen;
      logic        clk_req_oe;
      logic        clk_req_out;
      logic        clk_req_seen_n;
   } ctrl_state_t;

   ctrl_state_t state;
   ctrl_state_t next_state;

   logic        perst_n_sync;
   logic        clk_req_sync;
   logic        l0s_idle_expired;
   logic        l1_idle_expired;
   logic        l0s_allowed;
   logic        l1_aspm_allowed;
   dev_state_t  dev_calc;
   logic        clk_release;
   logic        l0s_go;
   logic        l1_go;
   logic        link_in_l1;
   logic        dev_powered;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   pin_sync #(
      .WIDTH (1)
   ) u_perst_sync (
      .clk_sys      (clk_sys),
      .resetn       (resetn),
      .pin_in       (perst_pin_n),
      .pin_sync_out (perst_n_sync)
   );

   pin_sync #(
      .WIDTH (1)
   ) u_clkreq_sync (
      .clk_sys      (clk_sys),
      .resetn       (resetn),
      .pin_in       (clk_request_pin_in),
      .pin_sync_out (clk_req_sync)
   );

   // ****************************************************************
   // idle timers
   // ****************************************************************
   assign l0s_allowed     = state.cfg.l0s_en && state.dev_state == DEV_D0;
   assign l1_aspm_allowed = state.cfg.l1_en && state.cfg.partner_l1_en
                            && state.dev_state == DEV_D0;

   idle_timer #(
      .LIMIT (L0S_IDLE),
      .CW    (IDLE_CW)
   ) u_l0s_timer (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .enable  (l0s_allowed && state.link_state == LINK_L0),
      .idle    (link_evt.tx_idle),
      .expired (l0s_idle_expired)
   );

   idle_timer #(
      .LIMIT (L1_IDLE),
      .CW    (IDLE_CW)
   ) u_l1_timer (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .enable  (l1_aspm_allowed && (state.link_state == LINK_L0
                                    || state.link_state == LINK_L0S)),
      .idle    (link_evt.link_idle),
      .expired (l1_idle_expired)
   );

   // ****************************************************************
   // entry decisions and state groups
   // ****************************************************************
   assign l0s_go      = l0s_idle_expired && l0s_allowed;
   assign l1_go       = l1_idle_expired && l1_aspm_allowed;
   assign link_in_l1  = state.link_state == LINK_L1
                        || state.link_state == LINK_L1_ASPM;
   assign dev_powered = state.dev_state == DEV_D0
                        || state.dev_state == DEV_D3HOT;

   // ****************************************************************
   // device state decode
   // ****************************************************************
   always_comb begin
      if (state.cfg.power_state != PWR_STATE_D3) begin
         dev_calc = DEV_D0;
      end else if (perst_n_sync) begin
         dev_calc = DEV_D3HOT;
      end else begin
         dev_calc = DEV_D3COLD;
      end
   end

   // ****************************************************************
   // clock request release condition
   // ****************************************************************
   assign clk_release = state.cfg.clk_mgmt_en
                        && link_in_l1
                        && dev_powered;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_state           = state;
      next_state.cfg       = cfg;
      next_state.dev_state = dev_calc;

      // turn-off handshake tracking
      if (link_evt.pme_turn_off_rx) begin
         next_state.turn_off_seen  = 1'b1;
         next_state.pme_to_ack_req = 1'b1;
      end else if (link_evt.pme_to_ack_sent) begin
         next_state.pme_to_ack_req = 1'b0;
      end

      unique case (state.link_state)
         LINK_LDN: begin
            if (link_evt.link_up && !link_evt.link_down && perst_n_sync) begin
               next_state.link_state = LINK_L0;
            end
         end
         LINK_L0: begin
            if (state.turn_off_seen && link_evt.pme_to_ack_sent) begin
               next_state.link_state = LINK_L23_READY;
            end else if (state.dev_state == DEV_D3HOT) begin
               next_state.link_state = LINK_L1;
            end else if (l1_go) begin
               next_state.link_state = LINK_L1_ASPM;
            end else if (l0s_go) begin
               next_state.link_state = LINK_L0S;
            end
         end
         LINK_L0S: begin
            if (!link_evt.tx_idle || !l0s_allowed) begin
               next_state.link_state = LINK_L0;
            end else if (l1_go) begin
               next_state.link_state = LINK_L1_ASPM;
            end
         end
         LINK_L1_ASPM: begin
            if (!link_evt.link_idle || !l1_aspm_allowed) begin
               next_state.link_state = LINK_L0;
            end
         end
         LINK_L1: begin
            if (state.dev_state == DEV_D0) begin
               next_state.link_state = LINK_L0;
            end
         end
         LINK_L23_READY: begin
            if (!perst_n_sync) begin
               next_state.link_state = LINK_L2;
            end
         end
         LINK_L2: begin
            if (perst_n_sync) begin
               next_state.link_state    = LINK_LDN;
               next_state.turn_off_seen = 1'b0;
            end
         end
      endcase

      // link loss or fundamental reset drops to the pseudo-state, except from LINK_L23_READY and LINK_L2
      if (state.link_state != LINK_L23_READY && state.link_state != LINK_L2
          && state.link_state != LINK_LDN
          && (link_evt.link_down || !perst_n_sync)) begin
         next_state.link_state    = LINK_LDN;
         next_state.turn_off_seen = 1'b0;
      end

      // handshake lost when leaving through link down
      if (next_state.link_state == LINK_LDN) begin
         next_state.pme_to_ack_req = 1'b0;
      end

      // derived outputs
      next_state.txn_allowed    = next_state.link_state == LINK_L0;
      unique case (next_state.link_state)
         LINK_L0, LINK_L0S, LINK_L1_ASPM, LINK_L1: begin
            next_state.cfg_msg_accept = next_state.dev_state != DEV_D3COLD;
         end
         default: begin
            next_state.cfg_msg_accept = 1'b0;
         end
      endcase
      next_state.tx_l0s_req     = next_state.link_state == LINK_L0S;
      next_state.l1_entry_req   = next_state.link_state == LINK_L1
                                  || next_state.link_state == LINK_L1_ASPM;

      // open-drain clock request: drive low unless released
      next_state.clk_req_out    = PIN_DRIVE_LEVEL;
      next_state.clk_req_oe     = !clk_release;
      next_state.clk_req_seen_n = clk_req_sync;
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state <= '{
            cfg: '{l0s_en: 1'b0, l1_en: 1'b0, partner_l1_en: 1'b0,
                   clk_mgmt_en: 1'b0, power_state: PWR_STATE_RESET},
            link_state:     LINK_LDN,
            dev_state:      DEV_D0,
            txn_allowed:    1'b0,
            cfg_msg_accept: 1'b0,
            tx_l0s_req:     1'b0,
            l1_entry_req:   1'b0,
            pme_to_ack_req: 1'b0,
            turn_off_seen:  1'b0,
            clk_req_oe:     1'b1,
            clk_req_out:    PIN_DRIVE_LEVEL,
            clk_req_seen_n: 1'b0
         };
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign clk_request_pin_out   = state.clk_req_out;
   assign clk_request_pin_oe    = state.clk_req_oe;
   assign clk_request_seen_n    = state.clk_req_seen_n;
   assign status.link_state     = state.link_state;
   assign status.dev_state      = state.dev_state;
   assign status.txn_allowed    = state.txn_allowed;
   assign status.cfg_msg_accept = state.cfg_msg_accept;
   assign status.tx_l0s_req     = state.tx_l0s_req;
   assign status.l1_entry_req   = state.l1_entry_req;
   assign status.pme_to_ack_req = state.pme_to_ack_req;

endmodule // pm_state_ctrl
`default_nettype wire

//--- dv/pm_state_ctrl_properties.sv
// concurrent checks of the power state control block
`timescale 1ns/1ns
`default_nettype none
module pm_state_ctrl_props
   import pm_state_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        perst_pin_n,
   input  wire pm_cfg_t     cfg,
   input  wire link_event_t link_evt,
   input  wire logic        clk_request_pin_in,
   input  wire logic        clk_request_pin_out,
   input  wire logic        clk_request_pin_oe,
   input  wire logic        clk_request_seen_n,
   input  wire pm_status_t  status
);
   // ********************
   // properties
   // ********************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_hot_decode: assert property (
      (cfg.power_state == 2'h3 && perst_pin_n) [*6] |-> status.dev_state == DEV_D3HOT)
      else $error("d3hot not decoded");
   a_cold_decode: assert property (
      (cfg.power_state == 2'h3 && !perst_pin_n) [*6] |-> status.dev_state == DEV_D3COLD)
      else $error("d3cold not decoded");
   a_no_mid_state: assert property (
      (cfg.power_state != 2'h3) [*6] |-> status.dev_state == DEV_D0)
      else $error("intermediate device state");
   a_req_held_on: assert property (
      (!cfg.clk_mgmt_en) [*3] |-> clk_request_pin_oe)
      else $error("request released while disabled");
   a_release_in_l1: assert property (
      !clk_request_pin_oe |-> $past(status.link_state) inside {LINK_L1, LINK_L1_ASPM}
      && $past(status.dev_state) != DEV_D3COLD && $past(cfg.clk_mgmt_en, 2))
      else $error("request released outside l1");
   a_pin_drive_low: assert property (clk_request_pin_out == 1'b0)
      else $error("pin driven high");
   a_l0_traffic: assert property (
      status.txn_allowed == (status.link_state == LINK_L0))
      else $error("traffic gate wrong");
   a_l0s_enable: assert property (
      $rose(status.tx_l0s_req) |-> $past(cfg.l0s_en, 2) && $past(link_evt.tx_idle, 2))
      else $error("l0s without enable");
   a_aspm_enable: assert property (
      $rose(status.link_state == LINK_L1_ASPM)
      |-> $past(cfg.l1_en && cfg.partner_l1_en, 2) && $past(status.dev_state) == DEV_D0)
      else $error("aspm l1 without enables");
   a_hot_to_l1: assert property (
      status.dev_state == DEV_D3HOT && status.link_state == LINK_L0
      |=> status.link_state == LINK_L1) else $error("d3hot did not enter l1");
   a_ready_after_ack: assert property (
      $rose(status.link_state == LINK_L23_READY) |-> $past(status.pme_to_ack_req))
      else $error("ready without handshake");
   a_l0_via_ldn: assert property (
      $rose(status.link_state == LINK_L0)
      |-> !($past(status.link_state) inside {LINK_L23_READY, LINK_L2}))
      else $error("l0 entered from deep state");
   a_hot_accepts: assert property (
      status.dev_state == DEV_D3HOT && status.link_state == LINK_L1 |-> status.cfg_msg_accept)
      else $error("d3hot refuses requests");

   c_l0s: cover property (status.link_state == LINK_L0S);
   c_released: cover property (!clk_request_pin_oe && status.dev_state == DEV_D3HOT);
   c_l2: cover property (status.link_state == LINK_L2);
endmodule // pm_state_ctrl_props

bind pm_state_ctrl pm_state_ctrl_props u_props (.clk_sys(clk_sys), .resetn(resetn),
   .perst_pin_n(perst_pin_n), .cfg(cfg), .link_evt(link_evt),
   .clk_request_pin_in(clk_request_pin_in), .clk_request_pin_out(clk_request_pin_out),
   .clk_request_pin_oe(clk_request_pin_oe), .clk_request_seen_n(clk_request_seen_n),
   .status(status));
`default_nettype wire

//--- dv/root_port_model.sv
// root complex side model: training, turn-off handshake, clock request wire
`timescale 1ns/1ns
`default_nettype none
module root_port_model (
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       perst_pin_n,
   input  wire logic       send_off,
   input  wire logic       ack_req,
   input  wire logic [3:0] ack_delay,
   input  wire logic       req_out,
   input  wire logic       req_oe,
   output var  logic       req_wire,
   output var  logic       link_up,
   output var  logic       turn_off,
   output var  logic       ack_sent
);
   logic [3:0] cnt;

   assign req_wire = req_oe ? req_out : 1'b1;

   always_ff @(posedge clk_sys) begin
      link_up  <= resetn & perst_pin_n;
      turn_off <= resetn & send_off;
      ack_sent <= resetn & ack_req & (cnt == ack_delay);
      cnt      <= (resetn & ack_req) ? cnt + 4'h1 : 4'h0;
   end
endmodule // root_port_model
`default_nettype wire

//--- dv/tb_pm_state_ctrl.sv
// self-checking bench of the power state control block
`timescale 1ns/1ns
`default_nettype none
module tb_pm_state_ctrl;
   import pm_state_pkg::*;
   logic        clk_sys = 0;
   logic        resetn = 0;
   logic        perst_pin_n = 0;
   logic        send_off = 0;
   logic        ld = 0;
   logic        txi = 0;
   logic        lki = 0;
   logic [3:0]  dly = 4'h0;
   logic        lu, to, ak, wire_lvl, req_out, req_oe;
   logic        seen_n;
   pm_cfg_t     cfg = '0;
   link_event_t link_evt;
   pm_status_t  status;
   int          miscompares = 0;
   int          num_checks = 0;

   assign link_evt = {lu, ld, txi, lki, to, ak};

   pm_state_ctrl #(.L0S_IDLE(2), .L1_IDLE(4)) DUT (.clk_sys(clk_sys), .resetn(resetn),
      .perst_pin_n(perst_pin_n), .cfg(cfg), .link_evt(link_evt),
      .clk_request_pin_in(wire_lvl), .clk_request_pin_out(req_out),
      .clk_request_pin_oe(req_oe), .clk_request_seen_n(seen_n), .status(status));
   root_port_model P (.clk_sys(clk_sys), .resetn(resetn), .perst_pin_n(perst_pin_n),
      .send_off(send_off), .ack_req(status.pme_to_ack_req), .ack_delay(dly),
      .req_out(req_out), .req_oe(req_oe), .req_wire(wire_lvl), .link_up(lu),
      .turn_off(to), .ack_sent(ak));

   initial forever #5 clk_sys = ~clk_sys;

   // ********************
   // helpers
   // ********************
   function automatic int exp_dev(int ps, int pr);
      return (ps == 3) ? (pr ? 1 : 2) : 0;
   endfunction
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wt(link_state_t e);
      for (int i = 0; i < 40 && status.link_state !== e; i++) @(negedge clk_sys);
      chk("link_state", status.link_state, e);
   endtask
   task automatic wrap_up;
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ********************
   // reference model
   // ********************
   int          ps_q[$];
   int          pr_q[$];
   int          mg_q[$];
   int          up_cnt = 0;
   always @(posedge clk_sys) begin
      ps_q.push_front(cfg.power_state);
      pr_q.push_front(perst_pin_n);
      mg_q.push_front(cfg.clk_mgmt_en);
      if (ps_q.size() > 3) begin
         void'(ps_q.pop_back());
         void'(pr_q.pop_back());
         void'(mg_q.pop_back());
      end
      up_cnt <= resetn ? up_cnt + 1 : 0;
   end
   always @(negedge clk_sys) begin
      if (up_cnt > 3) begin
         chk("dev model", status.dev_state, 8'(exp_dev(ps_q[1], pr_q[2])));
         if (mg_q[1] == 0) begin
            chk("oe model", req_oe, 1'b1);
         end
      end
   end

   // ********************
   // scenarios
   // ********************
   initial begin
      void'($urandom(91));
      cyc(20);
      resetn <= 1;
      @(negedge clk_sys);
      chk("reset oe", req_oe, 1'b1);
      chk("pin out", req_out, 1'b0);
      cyc(1);
      perst_pin_n <= 1;
      wt(LINK_L0);
      chk("txn", status.txn_allowed, 1'b1);
      for (int i = 0; i < 8; i++) begin
         cyc(1);
         cfg.power_state <= 2'($urandom % 3);
         cfg.clk_mgmt_en <= 1'($urandom);
         cyc(5);
         @(negedge clk_sys);
         chk("dev", status.dev_state, 8'(exp_dev(cfg.power_state, 1)));
         chk("oe in l0", req_oe, 1'b1);
      end
      cyc(1);
      cfg <= '0;
      txi <= 1;
      cyc(12);
      chk("l0s off", status.link_state, LINK_L0);
      cfg.l0s_en <= 1;
      wt(LINK_L0S);
      chk("l0s req", status.tx_l0s_req, 1'b1);
      cyc(1);
      txi <= 0;
      cfg.l1_en <= 1;
      lki <= 1;
      cyc(12);
      chk("aspm one side", status.link_state, LINK_L0);
      cfg.partner_l1_en <= 1;
      cfg.clk_mgmt_en <= 1;
      wt(LINK_L1_ASPM);
      chk("l1 req aspm", status.l1_entry_req, 1'b1);
      cyc(3);
      @(negedge clk_sys);
      chk("oe aspm", req_oe, 1'b0);
      chk("wire pulled", wire_lvl, 1'b1);
      cyc(1);
      lki <= 0;
      cfg <= 6'h03;
      wt(LINK_L1);
      chk("d3hot", status.dev_state, DEV_D3HOT);
      chk("l1 req", status.l1_entry_req, 1'b1);
      chk("accept d3hot", status.cfg_msg_accept, 1'b1);
      cyc(4);
      chk("oe held", req_oe, 1'b1);
      chk("seen low", seen_n, 1'b0);
      cfg.clk_mgmt_en <= 1;
      cyc(4);
      @(negedge clk_sys);
      chk("oe d3hot", req_oe, 1'b0);
      cyc(1);
      @(negedge clk_sys);
      chk("seen high", seen_n, 1'b1);
      cyc(1);
      cfg.power_state <= 2'h0;
      wt(LINK_L0);
      cyc(4);
      chk("oe l0", req_oe, 1'b1);
      dly <= 4'($urandom % 8);
      send_off <= 1;
      cyc(1);
      send_off <= 0;
      cyc(1);
      @(negedge clk_sys);
      chk("ack req", status.pme_to_ack_req, 1'b1);
      wt(LINK_L23_READY);
      chk("ack done", status.pme_to_ack_req, 1'b0);
      cyc(1);
      cfg.power_state <= 2'h3;
      perst_pin_n <= 0;
      wt(LINK_L2);
      cyc(4);
      @(negedge clk_sys);
      chk("d3cold", status.dev_state, DEV_D3COLD);
      chk("oe d3cold", req_oe, 1'b1);
      chk("accept d3cold", status.cfg_msg_accept, 1'b0);
      cyc(1);
      perst_pin_n <= 1;
      cfg.power_state <= 2'h0;
      wt(LINK_LDN);
      wt(LINK_L0);
      cyc(1);
      ld <= 1;
      wt(LINK_LDN);
      cyc(1);
      ld <= 0;
      wt(LINK_L0);
      wrap_up();
   end

   initial begin
      cyc(5000);
      miscompares++;
      wrap_up();
   end
endmodule // tb_pm_state_ctrl
`default_nettype wire
